/* File: hw/sbr_controller.sv */
// controller end: issues activate, access, precharge and refresh with timing
`timescale 1ns/1ps
module sbr_controller #(
  parameter int REFI_CYC = sbr_pkg::C_REFI
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // user request
  input  wire logic                         reqValid,
  input  wire logic                         reqWrite,
  input  wire logic                         reqAutoClose,
  input  wire logic [sbr_pkg::BANK_W-1:0]   reqBank,
  input  wire logic [sbr_pkg::ROW_W-1:0]    reqRow,
  input  wire logic [sbr_pkg::COL_W-1:0]    reqCol,
  input  wire logic                         selfReq,
  output logic                              reqReady,
  output logic                              inSelf,
  // link
  sbr_link_if.ctrl                          link
);

  localparam int CW = sbr_pkg::CNT_W;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ACT   = 7'h02,
    ST_ACC   = 7'h04,
    ST_PRE   = 7'h08,
    ST_REF   = 7'h10,
    ST_SELF  = 7'h20,
    ST_EXIT  = 7'h40
  } sbr_state_t;

  // ****************************************
  // sequencer
  // ****************************************
  sbr_state_t                 state, next_state;
  logic [CW-1:0]              waitCnt, next_waitCnt;
  logic [CW-1:0]              refCnt, next_refCnt;
  logic                       refDue, next_refDue;
  sbr_pkg::sbr_cmd_t          cmdQ, next_cmd;
  logic [sbr_pkg::BANK_W-1:0] bankQ, next_bank;
  logic [sbr_pkg::ADDR_W-1:0] addrQ, next_addr;
  logic                       gateQ, next_gate;
  logic                       next_reqReady;

  assign link.cmd     = cmdQ;
  assign link.bankSel = bankQ;
  assign link.addr    = addrQ;
  assign link.clkGate = gateQ;
  assign inSelf       = state[5];  // one-hot bit of the self refresh state

  always_comb begin
    next_state    = state;
    next_waitCnt  = (waitCnt != '0) ? waitCnt - 1'b1 : waitCnt;
    next_refCnt   = refCnt + 1'b1;
    next_refDue   = refDue;
    next_cmd      = sbr_pkg::SBR_NOP;
    next_bank     = bankQ;
    next_addr     = addrQ;
    next_gate     = 1'b1;
    next_reqReady = 1'b0;
    if (refCnt >= CW'(REFI_CYC - 1)) begin
      next_refCnt = '0;
      next_refDue = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        if (waitCnt == '0) begin
          if (refDue || selfReq) begin
            next_cmd     = sbr_pkg::SBR_REF;
            next_gate    = !(selfReq && !refDue);
            next_refDue  = 1'b0;
            next_waitCnt = CW'(sbr_pkg::C_RFC);
            next_state   = (selfReq && !refDue) ? ST_SELF : ST_REF;
            if (selfReq && !refDue) next_waitCnt = CW'(sbr_pkg::C_RAS);
          end else if (reqValid) begin
            next_cmd     = sbr_pkg::SBR_ACT;
            next_bank    = reqBank;
            next_addr    = sbr_pkg::ADDR_W'(reqRow);
            next_waitCnt = CW'(sbr_pkg::C_RCD - 1);
            next_state   = ST_ACT;
          end
        end
      end
      ST_ACT: begin
        if (waitCnt == '0) begin
          next_cmd      = reqWrite ? sbr_pkg::SBR_WRITE : sbr_pkg::SBR_READ;
          next_addr     = sbr_pkg::ADDR_W'(reqCol);
          next_addr[sbr_pkg::AUTO_CLOSE_BIT] = reqAutoClose;
          next_reqReady = 1'b1;
          next_waitCnt  = CW'(sbr_pkg::C_RAS);
          next_state    = reqAutoClose ? ST_ACC : ST_PRE;
        end
      end
      ST_ACC: begin
        // auto close: wait out row time plus same bank cycle time
        if (waitCnt == '0) begin
          next_waitCnt = CW'(sbr_pkg::C_RC);
          next_state   = ST_IDLE;
        end
      end
      ST_PRE: begin
        if (waitCnt == '0) begin
          next_cmd     = sbr_pkg::SBR_PRE;
          next_addr    = '0;
          next_waitCnt = CW'(sbr_pkg::C_RC);
          next_state   = ST_IDLE;
        end
      end
      ST_REF: begin
        if (waitCnt == '0) next_state = ST_IDLE;
      end
      ST_SELF: begin
        next_gate   = 1'b0;
        next_refCnt = '0;
        if (waitCnt == '0 && !selfReq) begin
          next_gate    = 1'b1;
          next_waitCnt = CW'(sbr_pkg::C_XSR);
          next_state   = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (waitCnt == '0) begin
          next_refDue = 1'b1;
          next_state  = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      waitCnt  <= '0;
      refCnt   <= '0;
      refDue   <= 1'b0;
      cmdQ     <= sbr_pkg::SBR_NOP;
      bankQ    <= '0;
      addrQ    <= '0;
      gateQ    <= 1'b1;
      reqReady <= 1'b0;
    end else begin
      state    <= next_state;
      waitCnt  <= next_waitCnt;
      refCnt   <= next_refCnt;
      refDue   <= next_refDue;
      cmdQ     <= next_cmd;
      bankQ    <= next_bank;
      addrQ    <= next_addr;
      gateQ    <= next_gate;
      reqReady <= next_reqReady;
    end
  end

endmodule : sbr_controller

/* File: hw/sbr_device.sv */
// memory device end: bank state, auto close, burst stop and refresh tracking
`timescale 1ns/1ps

// Overview of operation
// - auto close bit per access closes row
// - full page bursts ignore auto close
// - auto close applies to one access only
// - auto close at burst end, then precharge wait
// - burst stop cuts latest burst
// - burst stop leaves row open
// - controller precharges all, waits before refresh
// - refresh uses internal row counter
// - controller refreshes 4096 times per 64ms
// - controller may refresh in one burst
// - refresh with clock gate low enters self refresh
// - self refresh ignores all but clock gate
// - self refresh runs own internal refresh timer
// - controller holds self refresh row active minimum
// - controller restores clock before raising gate
// - controller sends idle commands for exit time
// - after exit refresh every 15.625 us
// - access only to activated bank
// - controller rounds times up to cycles
// - same bank reopen after precharge and cycle time
// - cross bank activates respect spacing
module sbr_device #(
  parameter int REFI_CYC = sbr_pkg::C_REFI
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // link
  sbr_link_if.dev                            link,
  // configuration
  input  wire logic                          fullPage,
  input  wire logic [sbr_pkg::BURST_W-1:0]   burstLen,
  // status
  output logic [sbr_pkg::BANKS-1:0]          bankOpen,
  output logic [sbr_pkg::ROW_W-1:0]          refreshRow,
  output logic                               selfRefresh,
  output logic                               burstActive,
  output logic                               illegalCmd
);

  // wait counters load one short: the loading edge is the first cycle
  localparam int CW = sbr_pkg::CNT_W;

  // ****************************************
  // state
  // ****************************************
  logic [sbr_pkg::BANKS-1:0]  next_bankOpen;
  logic [sbr_pkg::ROW_W-1:0]  next_refreshRow;
  logic                       next_selfRefresh;
  logic                       next_burstActive;
  logic                       next_illegalCmd;
  logic [sbr_pkg::BANK_W-1:0] burstBank, next_burstBank;
  logic                       burstClose, next_burstClose;
  logic [sbr_pkg::BURST_W-1:0] burstLeft, next_burstLeft;
  logic [CW-1:0]              bankWait [sbr_pkg::BANKS];
  logic [CW-1:0]              next_bankWait [sbr_pkg::BANKS];
  logic [CW-1:0]              bankRc [sbr_pkg::BANKS];
  logic [CW-1:0]              next_bankRc [sbr_pkg::BANKS];
  logic [CW-1:0]              rrdCnt, next_rrdCnt;
  logic [CW-1:0]              selfTimer, next_selfTimer;
  logic [CW-1:0]              exitCnt, next_exitCnt;

  always_comb begin
    logic [sbr_pkg::BANK_W-1:0] b;
    logic                       ac;
    logic                       waitBusy;
    waitBusy = 1'b0;
    b = link.bankSel;
    ac = link.addr[sbr_pkg::AUTO_CLOSE_BIT];
    next_bankOpen    = bankOpen;
    next_refreshRow  = refreshRow;
    next_selfRefresh = selfRefresh;
    next_burstActive = burstActive;
    next_burstBank   = burstBank;
    next_burstClose  = burstClose;
    next_burstLeft   = burstLeft;
    next_illegalCmd  = 1'b0;
    next_rrdCnt      = (rrdCnt != '0) ? rrdCnt - 1'b1 : rrdCnt;
    next_selfTimer   = selfTimer;
    next_exitCnt     = (exitCnt != '0) ? exitCnt - 1'b1 : exitCnt;
    for (int i = 0; i < sbr_pkg::BANKS; i++) begin
      next_bankWait[i] = (bankWait[i] != '0) ? bankWait[i] - 1'b1 : bankWait[i];
      next_bankRc[i]   = (bankRc[i] != '0) ? bankRc[i] - 1'b1 : bankRc[i];
      waitBusy         = waitBusy || (bankWait[i] != '0);
    end
    // burst progress and auto close at burst end
    if (burstActive && !fullPage) begin
      if (burstLeft <= sbr_pkg::BURST_W'(1)) begin
        next_burstActive = 1'b0;
        if (burstClose) begin
          next_bankOpen[burstBank] = 1'b0;
          next_bankWait[burstBank] = CW'(sbr_pkg::C_RP - 1);
        end
      end else begin
        next_burstLeft = burstLeft - 1'b1;
      end
    end
    if (selfRefresh) begin
      // only the clock gate is watched here
      if (link.clkGate) begin
        next_selfRefresh = 1'b0;
        next_exitCnt     = CW'(sbr_pkg::C_XSR - 1);
      end else if (selfTimer >= CW'(REFI_CYC - 1)) begin
        next_selfTimer   = '0;
        next_refreshRow  = refreshRow + 1'b1;
      end else begin
        next_selfTimer   = selfTimer + 1'b1;
      end
    end else begin
      case (link.cmd)
        sbr_pkg::SBR_NOP: begin
        end
        sbr_pkg::SBR_ACT: begin
          if (exitCnt != '0 || bankOpen[b] || bankWait[b] != '0 || bankRc[b] != '0 || rrdCnt != '0) begin
            next_illegalCmd = 1'b1;
          end else begin
            next_bankOpen[b] = 1'b1;
            next_bankWait[b] = CW'(sbr_pkg::C_RCD - 1);
            next_bankRc[b]   = CW'(sbr_pkg::C_RC - 1);
            next_rrdCnt      = CW'(sbr_pkg::C_RRD - 1);
          end
        end
        sbr_pkg::SBR_READ,
        sbr_pkg::SBR_WRITE: begin
          if (!bankOpen[b] || bankWait[b] != '0 || exitCnt != '0) begin
            next_illegalCmd = 1'b1;
          end else begin
            next_burstActive = 1'b1;
            next_burstBank   = b;
            next_burstLeft   = burstLen;
            next_burstClose  = ac && !fullPage;
          end
        end
        sbr_pkg::SBR_TERM: begin
          next_burstActive = 1'b0;
          next_burstClose  = 1'b0;
        end
        sbr_pkg::SBR_PRE: begin
          for (int i = 0; i < sbr_pkg::BANKS; i++) begin
            if ((ac || b == sbr_pkg::BANK_W'(i)) && bankOpen[i]) begin
              next_bankOpen[i] = 1'b0;
              next_bankWait[i] = CW'(sbr_pkg::C_RP - 1);
            end
          end
          if (burstActive && (ac || b == burstBank)) begin
            next_burstActive = 1'b0;
          end
        end
        sbr_pkg::SBR_REF: begin
          if (bankOpen != '0 || exitCnt != '0 || waitBusy) begin
            next_illegalCmd = 1'b1;
          end else begin
            for (int i = 0; i < sbr_pkg::BANKS; i++) begin
              next_bankWait[i] = CW'(sbr_pkg::C_RFC - 1);
            end
            next_refreshRow = refreshRow + 1'b1;
            if (!link.clkGate) begin
              next_selfRefresh = 1'b1;
              next_selfTimer   = '0;
            end
          end
        end
        default: begin
          next_illegalCmd = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bankOpen    <= '0;
      refreshRow  <= '0;
      selfRefresh <= 1'b0;
      burstActive <= 1'b0;
      illegalCmd  <= 1'b0;
      burstBank   <= '0;
      burstClose  <= 1'b0;
      burstLeft   <= '0;
      rrdCnt      <= '0;
      selfTimer   <= '0;
      exitCnt     <= '0;
      for (int i = 0; i < sbr_pkg::BANKS; i++) begin
        bankWait[i] <= '0;
        bankRc[i]   <= '0;
      end
    end else begin
      bankOpen    <= next_bankOpen;
      refreshRow  <= next_refreshRow;
      selfRefresh <= next_selfRefresh;
      burstActive <= next_burstActive;
      illegalCmd  <= next_illegalCmd;
      burstBank   <= next_burstBank;
      burstClose  <= next_burstClose;
      burstLeft   <= next_burstLeft;
      rrdCnt      <= next_rrdCnt;
      selfTimer   <= next_selfTimer;
      exitCnt     <= next_exitCnt;
      for (int i = 0; i < sbr_pkg::BANKS; i++) begin
        bankWait[i] <= next_bankWait[i];
        bankRc[i]   <= next_bankRc[i];
      end
    end
  end

endmodule : sbr_device

/* File: include/sbr_link_if.sv */
// interface: command link between controller and memory device
`timescale 1ns/1ps
interface sbr_link_if;
  sbr_pkg::sbr_cmd_t                 cmd;
  logic [sbr_pkg::BANK_W-1:0]        bankSel;
  logic [sbr_pkg::ADDR_W-1:0]        addr;
  logic                              clkGate;
  modport ctrl (output cmd, output bankSel, output addr, output clkGate);
  modport dev  (input cmd, input bankSel, input addr, input clkGate);
endinterface : sbr_link_if

/* File: include/sbr_pkg.sv */
// package: command codes, timing figures and cycle counts for the bank/refresh link
package sbr_pkg;

  // ****************************************
  // clock and geometry
  // ****************************************
  localparam int CLK_PERIOD_PS  = 10000;
  localparam int BANKS          = 4;
  localparam int BANK_W         = 2;
  localparam int ROW_W          = 12;
  localparam int COL_W          = 9;
  localparam int ADDR_W         = 12;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int BURST_W        = 4;

  // ****************************************
  // timing figures in picoseconds, plus exit minimum in cycles and refresh count
  // ****************************************
  localparam int T_PRECHARGE_WAIT_PS  = 20000;
  localparam int T_ACT_TO_ACCESS_PS   = 20000;
  localparam int T_SAME_BANK_ACT_PS   = 70000;
  localparam int T_CROSS_BANK_ACT_PS  = 20000;
  localparam int T_ROW_ACTIVE_MIN_PS  = 50000;
  localparam int T_SELF_EXIT_PS       = 80000;
  localparam int T_REFRESH_CYCLE_PS   = 70000;
  localparam int T_REFRESH_INTERVAL_PS = 15625000;
  localparam int SELF_EXIT_MIN_CYC    = 2;
  localparam int REFRESH_COUNT        = 4096;

  // ****************************************
  // derived cycle counts, least times rounded up
  // ****************************************
  localparam int C_RP   = (T_PRECHARGE_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_RCD  = (T_ACT_TO_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_RC   = (T_SAME_BANK_ACT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_RRD  = (T_CROSS_BANK_ACT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_RAS  = (T_ROW_ACTIVE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_XSR0 = (T_SELF_EXIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_XSR  = (C_XSR0 > SELF_EXIT_MIN_CYC) ? C_XSR0 : SELF_EXIT_MIN_CYC;
  localparam int C_RFC  = (T_REFRESH_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_REFI = T_REFRESH_INTERVAL_PS / CLK_PERIOD_PS;
  localparam int CNT_W  = 12;

  // ****************************************
  // command encodings: 3-bit codes numbered in sequence, NOP 0 through burst stop 6
  // ****************************************
  typedef enum logic [2:0] {
    SBR_NOP   = 3'h0,
    SBR_ACT   = 3'h1,
    SBR_READ  = 3'h2,
    SBR_WRITE = 3'h3,
    SBR_PRE   = 3'h4,
    SBR_REF   = 3'h5,
    SBR_TERM  = 3'h6
  } sbr_cmd_t;

endpackage : sbr_pkg

/* File: tb/sbr_link_chk.sv */
// checker: command timing on the link between the two ends
`timescale 1ns/1ps
module sbr_link_chk #(
  parameter int REFI_CYC = 50
) (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // link
  input wire logic [2:0]                 cmd,
  input wire logic [sbr_pkg::BANK_W-1:0] bankSel,
  input wire logic [sbr_pkg::ADDR_W-1:0] addr,
  input wire logic                       clkGate
);
  // ****
  // bank and gate tracking
  // ****
  localparam int SLACK = 24;  // room for closing a row before a due refresh
  logic [3:0] isOpen, next_isOpen;
  logic       acc, preOk;
  int         sAct[4], next_sAct[4], sPre[4], next_sPre[4];
  int         sAny, next_sAny, sRef, next_sRef, sHi, next_sHi, sLo, next_sLo;
  assign acc = cmd == sbr_pkg::SBR_READ || cmd == sbr_pkg::SBR_WRITE;
  always_comb begin
    next_isOpen = isOpen;
    preOk       = 1'b1;
    next_sAny   = sAny + 1;
    next_sRef   = clkGate ? sRef + 1 : 0;
    next_sHi    = clkGate ? sHi + 1 : 0;
    next_sLo    = clkGate ? 0 : sLo + 1;
    for (int b = 0; b < 4; b++) begin
      next_sAct[b] = sAct[b] + 1;
      next_sPre[b] = sPre[b] + 1;
      preOk        = preOk && sPre[b] >= sbr_pkg::C_RP;
      if ((cmd == sbr_pkg::SBR_PRE && (addr[10] || bankSel == 2'(b))) || (acc && addr[10] && bankSel == 2'(b))) begin
        next_isOpen[b] = 1'b0;
        next_sPre[b]   = 1;
      end
    end
    if (cmd == sbr_pkg::SBR_ACT) begin
      next_isOpen[bankSel] = 1'b1;
      next_sAct[bankSel]   = 1;
      next_sAny            = 1;
    end
    if (cmd == sbr_pkg::SBR_REF) next_sRef = 1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isOpen <= '0;
      sAct   <= '{default: 999};
      sPre   <= '{default: 999};
      sAny   <= 999;
      sRef   <= 0;
      sHi    <= 999;
      sLo    <= 0;
    end else begin
      isOpen <= next_isOpen;
      sAct   <= next_sAct;
      sPre   <= next_sPre;
      sAny   <= next_sAny;
      sRef   <= next_sRef;
      sHi    <= next_sHi;
      sLo    <= next_sLo;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  access_open_a: assert property (acc |-> isOpen[bankSel])
    else $error("access to a closed bank");
  access_delay_a: assert property (acc |-> sAct[bankSel] >= sbr_pkg::C_RCD)
    else $error("access too soon after activate");
  act_reopen_a: assert property (cmd == sbr_pkg::SBR_ACT |-> !isOpen[bankSel] && sAct[bankSel] >= sbr_pkg::C_RC
    && sPre[bankSel] >= sbr_pkg::C_RP) else $error("activate on a busy bank");
  act_spacing_a: assert property (cmd == sbr_pkg::SBR_ACT |-> sAny >= sbr_pkg::C_RRD)
    else $error("activates too close");
  refresh_closed_a: assert property (cmd == sbr_pkg::SBR_REF |-> isOpen == 4'h0 && preOk)
    else $error("refresh with a bank open or precharging");
  refresh_spacing_a: assert property (cmd == sbr_pkg::SBR_REF && clkGate |-> sRef >= sbr_pkg::C_RFC)
    else $error("refreshes too close");
  refresh_interval_a: assert property (sRef <= REFI_CYC + SLACK)
    else $error("refresh overdue");
  self_entry_a: assert property ($fell(clkGate) |-> cmd == sbr_pkg::SBR_REF)
    else $error("gate lowered without refresh command");
  self_hold_a: assert property ($rose(clkGate) |-> sLo >= sbr_pkg::C_RAS)
    else $error("self refresh left too early");
  exit_idle_a: assert property (clkGate && sHi < sbr_pkg::C_XSR |-> cmd == sbr_pkg::SBR_NOP)
    else $error("command during exit time");
endmodule : sbr_link_chk

/* File: tb/sdram_bank_refresh_cmds_bench.sv */
// testbench: controller and device joined, plus a device driven directly
`timescale 1ns/1ps
module sdram_bank_refresh_cmds_bench;
  localparam int REFI = 50;
  logic        clk, rst, reqValid, reqWrite, reqAutoClose, selfReq, reqReady, inSelf;
  logic        selfA, burstA, illA, fullPageB, selfB, burstB, illB, illSeen;
  logic [1:0]  reqBank;
  logic [11:0] reqRow, rowA, rowB, row0;
  logic [8:0]  reqCol;
  logic [3:0]  openA, openB, burstLenB;
  logic [31:0] r;
  int          error_cnt, total_checks, seed = 65;
  sbr_link_if linkA();
  sbr_link_if linkB();
  sbr_controller #(.REFI_CYC(REFI)) i_sbr_controller (.clk(clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAutoClose(reqAutoClose), .reqBank(reqBank), .reqRow(reqRow), .reqCol(reqCol), .selfReq(selfReq),
    .reqReady(reqReady), .inSelf(inSelf), .link(linkA));
  sbr_device #(.REFI_CYC(REFI)) i_sbr_device (.clk(clk), .rst(rst), .link(linkA), .fullPage(1'b0), .burstLen(4'h4),
    .bankOpen(openA), .refreshRow(rowA), .selfRefresh(selfA), .burstActive(burstA), .illegalCmd(illA));
  sbr_device #(.REFI_CYC(REFI)) i_sbr_device_b (.clk(clk), .rst(rst), .link(linkB), .fullPage(fullPageB),
    .burstLen(burstLenB), .bankOpen(openB), .refreshRow(rowB), .selfRefresh(selfB), .burstActive(burstB),
    .illegalCmd(illB));
  sbr_link_chk #(.REFI_CYC(REFI)) i_sbr_link_chk (.clk(clk), .rst(rst), .cmd(linkA.cmd), .bankSel(linkA.bankSel),
    .addr(linkA.addr), .clkGate(linkA.clkGate));
  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic request(input logic w, input logic ac, input logic [1:0] b, input logic [11:0] rw, input logic [8:0] c);
    int n;
    reqValid     = 1'b1;
    reqWrite     = w;
    reqAutoClose = ac;
    reqBank      = b;
    reqRow       = rw;
    reqCol       = c;
    n            = 0;
    do begin
      @(negedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 400);
    check(n < 400, 1);
    check(linkA.cmd, w ? sbr_pkg::SBR_WRITE : sbr_pkg::SBR_READ);
    check({linkA.bankSel, linkA.addr[10], linkA.addr[8:0]}, {b, ac, c});
    check(openA[b], 1);
    reqValid = 1'b0;
    @(negedge clk);
    check(burstA, 1);
  endtask : request
  task automatic waitSelf(input logic exp);
    int n;
    n = 0;
    while (inSelf !== exp && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(inSelf, exp);
  endtask : waitSelf
  task automatic putB(input sbr_pkg::sbr_cmd_t c, input logic [1:0] b, input logic [11:0] a);
    linkB.cmd     = c;
    linkB.bankSel = b;
    linkB.addr    = a;
    @(negedge clk);
  endtask : putB
  // idle, flip the released address lines, then look for a refusal
  task automatic endB(input logic exp);
    linkB.cmd  = sbr_pkg::SBR_NOP;
    linkB.addr = ~linkB.addr;
    repeat (3) @(negedge clk);
    check(illSeen, exp);
    illSeen = 1'b0;
  endtask : endB
  always @(negedge clk) if (illB === 1'b1) illSeen = 1'b1;
  always @(negedge clk) if (!rst && illA !== 1'b0) check(illA, 0);
  // ****
  // stimulus
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    {reqValid, reqWrite, reqAutoClose, selfReq, fullPageB, illSeen} = '0;
    {reqBank, reqRow, reqCol} = '0;
    burstLenB     = 4'h4;
    linkB.cmd     = sbr_pkg::SBR_NOP;
    linkB.bankSel = 2'h0;
    linkB.addr    = 12'h000;
    linkB.clkGate = 1'b1;
    rst           = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    request(1'b0, 1'b0, 2'h1, 12'h000, 9'h000);
    request(1'b1, 1'b1, 2'h1, 12'hFFF, 9'h1FF);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      request(r[0], r[1], r[3:2], r[15:4], r[24:16]);
    end
    selfReq = 1'b1;
    waitSelf(1'b1);
    @(negedge clk);
    check({selfA, linkA.clkGate}, 2'h2);
    row0 = rowA;
    repeat (200) @(negedge clk);
    check(rowA != row0, 1);
    selfReq = 1'b0;
    waitSelf(1'b0);
    repeat (12) @(negedge clk);
    check(selfA, 0);
    request(1'b1, 1'b0, 2'h3, 12'h055, 9'h0AA);
    putB(sbr_pkg::SBR_READ, 2'h0, 12'h000); endB(1);
    putB(sbr_pkg::SBR_ACT, 2'h1, 12'h123); endB(0);
    putB(sbr_pkg::SBR_ACT, 2'h1, 12'h000); endB(1);
    putB(sbr_pkg::SBR_ACT, 2'h2, 12'h000); putB(sbr_pkg::SBR_ACT, 2'h3, 12'h000); endB(1);
    check(openB, 4'h6);
    putB(sbr_pkg::SBR_READ, 2'h1, 12'h400); endB(0);
    repeat (10) @(negedge clk);
    check(openB[1], 0);
    putB(sbr_pkg::SBR_ACT, 2'h1, 12'h000); endB(0);
    putB(sbr_pkg::SBR_READ, 2'h1, 12'h000); endB(0);
    repeat (10) @(negedge clk);
    check({openB[1], burstB}, 2'h2);
    burstLenB = 4'h8;
    putB(sbr_pkg::SBR_READ, 2'h1, 12'h000); putB(sbr_pkg::SBR_TERM, 2'h1, 12'h000); endB(0);
    check({openB[1], burstB}, 2'h2);
    fullPageB = 1'b1;
    putB(sbr_pkg::SBR_READ, 2'h1, 12'h400); endB(0);
    repeat (20) @(negedge clk);
    check({openB[1], burstB}, 2'h3);
    putB(sbr_pkg::SBR_TERM, 2'h1, 12'h000); endB(0);
    check({openB[1], burstB}, 2'h2);
    r = $random(seed);
    putB(sbr_pkg::SBR_REF, r[1:0], r[13:2]); endB(1);
    putB(sbr_pkg::SBR_PRE, 2'h0, 12'h400); endB(0);
    row0 = rowB;
    putB(sbr_pkg::SBR_REF, r[1:0], r[13:2]); endB(0);
    check(rowB, 12'(row0 + 12'h001));
    repeat (sbr_pkg::C_RFC) @(negedge clk);
    linkB.clkGate = 1'b0;
    putB(sbr_pkg::SBR_REF, 2'h0, 12'h000); endB(0);
    check(selfB, 1);
    putB(sbr_pkg::SBR_ACT, 2'h0, 12'h000); endB(0);
    check(openB, 4'h0);
    repeat (sbr_pkg::C_RAS) @(negedge clk);
    linkB.clkGate = 1'b1;
    putB(sbr_pkg::SBR_NOP, 2'h0, 12'h000);
    putB(sbr_pkg::SBR_ACT, 2'h0, 12'h000); endB(1);
    repeat (sbr_pkg::C_XSR) @(negedge clk);
    check({selfB, openB}, 5'h00);
    test_done();
  end
endmodule : sdram_bank_refresh_cmds_bench
